//--- hdl/dcr_pkg.sv
/*
  Package for the DMA channel request-control slice: register offsets,
  field positions, reset values, timing constants and carrier structs.
  Assumes a 32-bit APB slave with word-aligned registers.
*/
package dcr_pkg;

  // ==========================================================
  // Register map (byte addresses)
  // ==========================================================
  localparam logic [7:0] DCR_CTRL_OFF = 8'h00;
  localparam logic [7:0] DCR_STAT_OFF = 8'h04;
  localparam logic [7:0] DCR_MASK_OFF = 8'h08;

  // ==========================================================
  // Control register fields
  // ==========================================================
  localparam int DCR_CHAN_RST_BIT = 24;
  localparam int DCR_REQ_POL_BIT = 21;
  localparam int DCR_REQ_EDGE_BIT = 20;
  localparam int DCR_EXT_MODE_BIT = 16;
  localparam int DCR_IVL_LSB = 13;
  localparam int DCR_IRQE_BIT = 12;
  localparam int DCR_IRQC_BIT = 11;
  localparam int DCR_IRQT_BIT = 10;
  localparam logic [31:0] DCR_CTRL_RST = 32'h0100_0000;
  localparam logic [31:0] DCR_CTRL_WMASK = 32'h0131_FC00;

  // ==========================================================
  // Status register fields (sticky, write one to clear)
  // ==========================================================
  localparam int DCR_ST_STALL = 0;
  localparam int DCR_ST_ERR = 1;
  localparam int DCR_ST_CHAIN = 2;
  localparam int DCR_ST_XFER = 3;
  localparam int DCR_ST_WIDTH = 4;
  localparam logic [3:0] DCR_STAT_RST = 4'h0;
  localparam logic [3:0] DCR_MASK_RST = 4'h0;

  // ==========================================================
  // Timing: stall intervals and request delays in clocks
  // ==========================================================
  localparam int DCR_STALL_UNIT = 64;
  localparam int DCR_DELAY_BASE = 16;
  localparam int DCR_CNT_W = 23;

  // ==========================================================
  // Carriers
  // ==========================================================
  typedef struct packed {
    logic stall_mask;
    logic error_end;
    logic chain_end;
    logic xfer_end;
  } dcr_events_t;

  typedef struct packed {
    logic channel_reset;
    logic polarity_high;
    logic edge_detect;
    logic external_mode;
    logic [2:0] interval;
    logic irq_err_en;
    logic irq_chain_en;
    logic irq_xfer_en;
  } dcr_ctrl_t;

endpackage

//--- hdl/dcr_channel_request.sv
/*
  Request generation, stall detection and interrupt gating for one DMA
  channel, with an APB register slave. Assumes the rest of the channel
  drives the ownership grant, active flag, wait count and end events.
*/
// Overview of operation
// (R01) In external mode, bus ownership is requested only on the device request.
// (R02) In memory mode, ownership is requested once the wait count is zero.
// (R03) In external mode, clocks without ownership are counted and stall set past the interval.
// (R04) Stall interval codes 0..7 give off, 960, 4032, 16320, 65472, 262080, 1048512, 4194240.
// (R05) In memory mode the same field delays the next request after release.
// (R06) Delay codes 0..7 give continuous, 16, 32, 64, 128, 256, 512, 1024 clocks.
// (R07) Error enable lets error end or stall raise the interrupt.
// (R08) Chain-end enable lets chain end raise the interrupt.
// (R09) Transfer-end enable lets transfer end raise the interrupt.
// (R10) Mode, interval and enables reset to zero.
// (R11) Request polarity and level or edge sampling are selectable.
// (R12) Channel reset clears channel logic, interrupts and requests.
// (R13) The stall counter restarts whenever ownership is regained.
`timescale 1ns/10ps
`default_nettype none
module dcr_channel_request
  import dcr_pkg::*;
#(
  parameter int STALL_UNIT = DCR_STALL_UNIT
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Channel side
  input wire logic external_dma_request_line,
  input wire logic channel_active,
  input wire logic bus_granted,
  input wire logic [15:0] wait_count,
  input wire logic error_end_event,
  input wire logic chain_end_event,
  input wire logic xfer_end_event,
  output logic bus_request,
  output logic channel_irq
);

  // ==========================================================
  // APB decode
  // ==========================================================
  logic access_w, write_w, ctrl_hit, stat_hit, mask_hit;
  assign access_w = psel & penable;
  assign write_w = access_w & pwrite;
  assign ctrl_hit = (paddr == DCR_CTRL_OFF);
  assign stat_hit = (paddr == DCR_STAT_OFF);
  assign mask_hit = (paddr == DCR_MASK_OFF);
  assign pready = 1'b1;
  assign pslverr = access_w & ~(ctrl_hit | stat_hit | mask_hit);

  // ==========================================================
  // Control register
  // ==========================================================
  logic [31:0] ctrl_q;
  dcr_ctrl_t ctl;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= DCR_CTRL_RST; // R10
    end else if (write_w && ctrl_hit) begin
      ctrl_q <= pwdata & DCR_CTRL_WMASK;
    end
  end
  assign ctl.channel_reset = ctrl_q[DCR_CHAN_RST_BIT];
  assign ctl.polarity_high = ctrl_q[DCR_REQ_POL_BIT];
  assign ctl.edge_detect = ctrl_q[DCR_REQ_EDGE_BIT];
  assign ctl.external_mode = ctrl_q[DCR_EXT_MODE_BIT];
  assign ctl.interval = ctrl_q[DCR_IVL_LSB+:3];
  assign ctl.irq_err_en = ctrl_q[DCR_IRQE_BIT];
  assign ctl.irq_chain_en = ctrl_q[DCR_IRQC_BIT];
  assign ctl.irq_xfer_en = ctrl_q[DCR_IRQT_BIT];

  logic run;
  assign run = ~ctl.channel_reset; // R12

  // ==========================================================
  // Request pin synchroniser and detection
  // ==========================================================
  logic [2:0] req_sync_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_sync_q <= 3'b000;
    end else begin
      req_sync_q <= {req_sync_q[1:0], external_dma_request_line};
    end
  end

  // Filtered level updates once stages two and three agree
  logic req_lvl_q, req_lvl_prev_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_lvl_q <= 1'b0;
      req_lvl_prev_q <= 1'b0;
    end else begin
      if (req_sync_q[1] == req_sync_q[2]) begin
        req_lvl_q <= req_sync_q[2];
      end
      req_lvl_prev_q <= req_lvl_q;
    end
  end

  logic req_asserted, req_edge;
  assign req_asserted = ctl.polarity_high ? req_lvl_q : ~req_lvl_q; // R11
  assign req_edge = ctl.polarity_high ? (req_lvl_q & ~req_lvl_prev_q)
                                      : (~req_lvl_q & req_lvl_prev_q);

  // Edge requests are latched until ownership is granted
  logic edge_pend_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_pend_q <= 1'b0;
    end else if (!run) begin
      edge_pend_q <= 1'b0; // R12
    end else if (req_edge) begin
      edge_pend_q <= 1'b1; // R11
    end else if (bus_granted) begin
      edge_pend_q <= 1'b0;
    end
  end

  logic dev_request;
  assign dev_request = ctl.edge_detect ? edge_pend_q : req_asserted; // R11

  // ==========================================================
  // Ownership release tracking
  // ==========================================================
  logic grant_prev_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grant_prev_q <= 1'b0;
    end else begin
      grant_prev_q <= bus_granted;
    end
  end
  logic release_evt;
  assign release_evt = grant_prev_q & ~bus_granted;

  // ==========================================================
  // Stall interval and request delay tables
  // ==========================================================
  logic [DCR_CNT_W-1:0] stall_limit, delay_limit;
  always_comb begin
    // (2^(2k+2)-1) * 64: 960, 4032, ... 4194240
    if (ctl.interval == 3'b000) begin
      stall_limit = '0; // R04
    end else begin
      stall_limit = DCR_CNT_W'(((32'd1 << (2 * ctl.interval + 2)) - 32'd1)
                    * STALL_UNIT); // R04
    end
    if (ctl.interval == 3'b000) begin
      delay_limit = '0; // R06
    end else begin
      delay_limit = DCR_CNT_W'(DCR_DELAY_BASE << (ctl.interval - 3'd1)); // R06
    end
  end

  // ==========================================================
  // Clocks-without-ownership counter
  // ==========================================================
  logic [DCR_CNT_W-1:0] idle_cnt_q;
  logic idle_run_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_q <= '0;
      idle_run_q <= 1'b0;
    end else if (!run || bus_granted) begin
      idle_cnt_q <= '0; // R13
      idle_run_q <= 1'b0;
    end else if (release_evt) begin
      idle_cnt_q <= DCR_CNT_W'(1);
      idle_run_q <= 1'b1;
    end else if (idle_run_q && idle_cnt_q != '1) begin
      idle_cnt_q <= idle_cnt_q + DCR_CNT_W'(1); // R03
    end
  end

  logic stall_hit;
  assign stall_hit = run & ctl.external_mode & idle_run_q
                   & (ctl.interval != 3'b000)
                   & (idle_cnt_q > stall_limit); // R03

  // Stall raised once per idle period
  logic stall_done_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_done_q <= 1'b0;
    end else if (!run || bus_granted) begin
      stall_done_q <= 1'b0;
    end else if (stall_hit) begin
      stall_done_q <= 1'b1;
    end
  end

  // ==========================================================
  // Bus request generation
  // ==========================================================
  logic delay_ok;
  // Release cycle itself already counts as held off
  assign delay_ok = (ctl.interval == 3'b000)
                  || (!idle_run_q && !release_evt)
                  || (idle_run_q && idle_cnt_q >= delay_limit); // R05

  always_comb begin
    if (!run || !channel_active) begin
      bus_request = 1'b0; // R12
    end else if (ctl.external_mode) begin
      bus_request = dev_request; // R01
    end else begin
      bus_request = (wait_count == 16'h0000) & delay_ok; // R02
    end
  end

  // ==========================================================
  // Status (sticky, W1C, set wins) and mask
  // ==========================================================
  logic [DCR_ST_WIDTH-1:0] stat_q, mask_q, evt, w1c;
  assign evt[DCR_ST_STALL] = stall_hit & ~stall_done_q;
  assign evt[DCR_ST_ERR] = error_end_event;
  assign evt[DCR_ST_CHAIN] = chain_end_event;
  assign evt[DCR_ST_XFER] = xfer_end_event;
  assign w1c = (write_w && stat_hit) ? pwdata[DCR_ST_WIDTH-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= DCR_STAT_RST;
    end else if (!run) begin
      stat_q <= DCR_STAT_RST; // R12
    end else begin
      stat_q <= (stat_q & ~w1c) | evt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= DCR_MASK_RST;
    end else if (write_w && mask_hit) begin
      mask_q <= pwdata[DCR_ST_WIDTH-1:0];
    end
  end

  // ==========================================================
  // Interrupt gating
  // ==========================================================
  dcr_events_t en;
  assign en.stall_mask = ctl.irq_err_en; // R07
  assign en.error_end = ctl.irq_err_en; // R07
  assign en.chain_end = ctl.irq_chain_en; // R08
  assign en.xfer_end = ctl.irq_xfer_en; // R09

  logic irq_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= run & |(stat_q & {en.xfer_end, en.chain_end, en.error_end,
                                 en.stall_mask} & mask_q);
    end
  end
  assign channel_irq = irq_q;

  // ==========================================================
  // Read data
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == DCR_CTRL_OFF) begin
        prdata <= ctrl_q;
      end else if (paddr == DCR_STAT_OFF) begin
        prdata <= {28'h000_0000, stat_q};
      end else if (paddr == DCR_MASK_OFF) begin
        prdata <= {28'h000_0000, mask_q};
      end else begin
        prdata <= '0;
      end
    end
  end

endmodule
`default_nettype wire

//--- verification/dcr_arbiter_model.sv
/*
  Behavioural bus arbiter for one channel.
  Assumes the bench gates it through enable.
*/
`timescale 1ns/10ps
`default_nettype none
module dcr_arbiter_model (
  // Clock and control
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  // Ownership handshake
  input wire logic bus_request,
  output logic bus_granted
);
  // ==========
  // Grant after random wait, hold four clocks
  logic [1:0] wait_q;
  logic [1:0] hold_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_granted <= 1'h0;
      wait_q <= 2'h0;
      hold_q <= 2'h0;
    end else if (!enable) begin
      bus_granted <= 1'h0;
    end else if (bus_granted) begin
      hold_q <= hold_q + 2'h1;
      bus_granted <= hold_q != 2'h3;
      wait_q <= 2'($urandom_range(3));
    end else if (bus_request && wait_q == 2'h0) begin
      bus_granted <= 1'h1;
    end else if (bus_request) begin
      wait_q <= wait_q - 2'h1;
    end
  end
endmodule
`default_nettype wire

//--- verification/dcr_channel_request_props.sv
/*
  Port checker for the request-control slice.
  Assumes zero-wait APB writes; bound below.
*/
`timescale 1ns/10ps
`default_nettype none
module dcr_channel_request_props
  import dcr_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // Channel
  input wire logic external_dma_request_line,
  input wire logic channel_active,
  input wire logic bus_granted,
  input wire logic [15:0] wait_count,
  input wire logic error_end_event,
  input wire logic chain_end_event,
  input wire logic xfer_end_event,
  input wire logic bus_request,
  input wire logic channel_irq
);
  // ==========
  // Shadow registers
  logic [31:0] c_q;
  logic [3:0] m_q;
  logic [2:0] idle_q;
  logic wr;
  assign wr = psel && penable && pwrite && pready;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_q <= DCR_CTRL_RST;
      m_q <= DCR_MASK_RST;
    end else if (wr && paddr == DCR_CTRL_OFF) begin
      c_q <= pwdata & DCR_CTRL_WMASK;
    end else if (wr && paddr == DCR_MASK_OFF) begin
      m_q <= pwdata[3:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_q <= 3'h0;
    end else if (external_dma_request_line == c_q[21]) begin
      idle_q <= 3'h0;
    end else if (idle_q != 3'h7) begin
      idle_q <= idle_q + 3'h1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_mem_no_req: assert property (
    !c_q[16] && wait_count != 16'h0000 |-> !bus_request)
    else $error("request while wait count nonzero");
  a_mem_req_on: assert property (
    !c_q[24] && c_q[16:13] == 4'h0 && channel_active &&
    wait_count == 16'h0000 && !bus_granted |-> bus_request)
    else $error("no request in memory mode");
  a_ext_no_req: assert property (
    c_q[16] && !c_q[20] && idle_q == 3'h7 |-> !bus_request)
    else $error("request without device request");
  a_rst_quiet: assert property (
    c_q[24] [*2] |-> !bus_request && !channel_irq)
    else $error("activity in channel reset");
  a_irq_off: assert property (
    c_q[12:10] == 3'h0 && $past(c_q[12:10]) == 3'h0 |-> !channel_irq)
    else $error("interrupt with enables off");
  a_err_irq: assert property (
    error_end_event && c_q[12] && m_q[1] && !c_q[24]
    |-> ##[1:3] channel_irq)
    else $error("error end gave no interrupt");
  a_chain_irq: assert property (
    $rose(chain_end_event) && c_q[11] && m_q[2] && !c_q[24]
    |-> ##[1:3] channel_irq)
    else $error("chain end gave no interrupt");
  a_xfer_irq: assert property (
    xfer_end_event && c_q[10] && m_q[3] && !c_q[24]
    |=> ##[0:2] channel_irq)
    else $error("transfer end gave no interrupt");
endmodule
bind dcr_channel_request dcr_channel_request_props chk_u (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .external_dma_request_line, .channel_active, .bus_granted, .wait_count,
  .error_end_event, .chain_end_event, .xfer_end_event, .bus_request,
  .channel_irq
);
`default_nettype wire

//--- verification/tb_dcr_channel_request.sv
/*
  Self-checking bench for the request-control slice.
  Assumes the arbiter model and a stall unit of one.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_dcr_channel_request;
  import dcr_pkg::*;
  // ==========
  // Wiring
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic pready, pslverr, bus_granted, bus_request, channel_irq;
  logic external_dma_request_line = '0, channel_active = '1, arb_en = '1;
  logic error_end_event = '0, chain_end_event = '0, xfer_end_event = '0;
  logic [15:0] wait_count = '0;
  logic [31:0] exp_q[$];
  int n_mismatch = 0, cmp_count = 0, n;
  always #20 pclk = ~pclk;
  dcr_channel_request #(.STALL_UNIT(1)) dut_u (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .external_dma_request_line, .channel_active, .bus_granted, .wait_count,
    .error_end_event, .chain_end_event, .xfer_end_event, .bus_request,
    .channel_irq);
  dcr_arbiter_model arb_u (.pclk, .presetn, .enable(arb_en), .bus_request,
    .bus_granted);
  // ==========
  // Tasks
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    exp_q.push_back(e);
    apb(1'h0, a, '0);
  endtask
  task automatic pulse(logic [2:0] e);
    @(posedge pclk);
    {error_end_event, chain_end_event, xfer_end_event} <= e;
    @(posedge pclk);
    {error_end_event, chain_end_event, xfer_end_event} <= 3'h0;
    repeat (3) @(posedge pclk);
    #1;
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Read data and error checker
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      chk("pslverr", 32'(paddr > DCR_MASK_OFF), 32'(pslverr));
      if (!pwrite) chk("prdata", exp_q.pop_front(), prdata);
    end
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    wrap_up;
  end
  // ==========
  // Scenarios
  initial begin
    r = $urandom(51);
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    rd(DCR_CTRL_OFF, DCR_CTRL_RST);
    rd(DCR_STAT_OFF, '0);
    rd(DCR_MASK_OFF, '0);
    rd(8'h0C, '0);
    chk("request", '0, 32'(bus_request));
    r = $urandom;
    wr(DCR_CTRL_OFF, r);
    rd(DCR_CTRL_OFF, r & DCR_CTRL_WMASK);
    wr(DCR_MASK_OFF, 32'h0000_000F);
    wr(DCR_CTRL_OFF, '0);
    wait_count <= 16'h0005;
    repeat (6) @(posedge pclk);
    #1 chk("request", '0, 32'(bus_request));
    wait_count <= '0;
    #1 chk("request", 32'h1, 32'(bus_request));
    for (int k = 1; k < 8; k++) begin
      wr(DCR_CTRL_OFF, 32'(k) << DCR_IVL_LSB);
      @(negedge bus_granted);
      n = 0;
      do begin
        @(posedge pclk);
        #1 n++;
      end while (bus_request !== 1'h1 && n < 2000);
      chk("delay", 32'h1, 32'(n > (8 << k) - 3 && n < (8 << k) + 3));
    end
    $display("end memory request");
    arb_en <= 1'h0;
    for (int p = 0; p < 2; p++) begin
      external_dma_request_line <= !p;
      wr(DCR_CTRL_OFF, 32'h0001_0000 | 32'(p) << DCR_REQ_POL_BIT);
      repeat (6) @(posedge pclk);
      #1 chk("request", '0, 32'(bus_request));
      external_dma_request_line <= p[0];
      repeat (6) @(posedge pclk);
      #1 chk("request", 32'h1, 32'(bus_request));
    end
    external_dma_request_line <= 1'h0;
    wr(DCR_CTRL_OFF, 32'h0031_0000);
    repeat (6) @(posedge pclk);
    external_dma_request_line <= 1'h1;
    repeat (3) @(posedge pclk);
    external_dma_request_line <= 1'h0;
    repeat (6) @(posedge pclk);
    #1 chk("request", 32'h1, 32'(bus_request));
    arb_en <= 1'h1;
    @(posedge bus_granted);
    repeat (6) @(posedge pclk);
    #1 chk("request", '0, 32'(bus_request));
    $display("end external request");
    wr(DCR_CTRL_OFF, 32'h0021_3000);
    external_dma_request_line <= 1'h1;
    @(posedge bus_granted);
    external_dma_request_line <= 1'h0;
    repeat (6) @(posedge pclk);
    arb_en <= 1'h0;
    repeat (6) @(posedge pclk);
    rd(DCR_STAT_OFF, '0);
    repeat (14) @(posedge pclk);
    rd(DCR_STAT_OFF, 32'h1);
    #1 chk("irq", 32'h1, 32'(channel_irq));
    $display("end stall");
    wr(DCR_CTRL_OFF, '0);
    wr(DCR_STAT_OFF, 32'h0000_000F);
    pulse(3'h7);
    chk("irq", '0, 32'(channel_irq));
    rd(DCR_STAT_OFF, 32'h0000_000E);
    for (int k = 0; k < 3; k++) begin
      wr(DCR_STAT_OFF, 32'h0000_000F);
      wr(DCR_CTRL_OFF, 32'h0000_1000 >> k);
      pulse(3'h4 >> k);
      chk("irq", 32'h1, 32'(channel_irq));
      rd(DCR_STAT_OFF, 32'h2 << k);
    end
    $display("end interrupts");
    wr(DCR_CTRL_OFF, 32'h0100_0400);
    repeat (2) @(posedge pclk);
    #1 chk("irq", '0, 32'(channel_irq));
    chk("request", '0, 32'(bus_request));
    rd(DCR_STAT_OFF, '0);
    $display("end channel reset");
    wrap_up;
  end
endmodule
`default_nettype wire
